// [hdl/pin_mapper_pkg.sv]
package pin_mapper_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] MODE_LO_IDX = 16'h0100;  // drive/combine fields, pins 0..3
  localparam logic [15:0] MODE_HI_IDX = 16'h0101;  // drive/combine fields, pins 4..7
  localparam logic [15:0] FUNC_BASE_IDX = 16'h0102;  // first pin function register
  localparam logic [15:0] PIN_LEVEL_IDX = 16'h0110;  // read-only pin levels and control state
  localparam int PINS_PER_MODE_REG = 4;

  // function register fields
  localparam int OE_BIT = 7;  // one: status output, zero: control input
  localparam int CODE_MSB = 6;  // code occupies bits 6..0
  localparam logic [7:0] FUNC_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'b00;
  localparam int MODE_OR_BIT = 1;  // set: pin joins the OR group
  localparam int MODE_INV_BIT = 0;  // set: pin level is inverted

  // control codes and the slot each drives
  localparam int NUM_CTRL = 10;
  localparam int CTRL_IO_UPDATE = 0;  // transfer strobe
  localparam int CTRL_POWER_DOWN = 1;
  localparam int CTRL_WD_CLEAR = 2;
  localparam int CTRL_SYNC_ALL = 3;
  localparam int CTRL_IRQ_CLR_ALL = 4;  // four clear slots follow in order
  localparam int CTRL_FAULT_A = 8;  // two force-fault slots follow
  localparam logic [NUM_CTRL-1:0][6:0] CTRL_CODES = {
    7'h21, 7'h20, 7'h13, 7'h12, 7'h11, 7'h10, 7'h04, 7'h03, 7'h02, 7'h01};

  // status codes
  localparam logic [6:0] ST_ZERO = 7'h00;
  localparam logic [6:0] ST_ONE = 7'h01;
  localparam logic [6:0] ST_CORE_CLK = 7'h02;
  localparam logic [6:0] ST_WD_TIMEOUT = 7'h03;
  localparam logic [6:0] ST_SYSTEM_CLOCK_SOURCE_CAL = 7'h04;
  localparam logic [6:0] ST_SYSTEM_CLOCK_SOURCE_LOCK = 7'h05;
  localparam logic [6:0] ST_SYSTEM_CLOCK_SOURCE_STABLE = 7'h06;
  localparam logic [6:0] ST_BOTH_LOCK = 7'h07;
  localparam logic [6:0] ST_CH0_LOCK = 7'h08;
  localparam logic [6:0] ST_CH1_LOCK = 7'h09;
  localparam logic [6:0] ST_NV_SAVE = 7'h0a;
  localparam logic [6:0] ST_NV_LOAD = 7'h0b;
  localparam logic [6:0] ST_NV_FAULT = 7'h0c;
  localparam logic [6:0] ST_TEMP_ALARM = 7'h0d;
  localparam logic [6:0] ST_IRQ_ANY = 7'h10;
  localparam logic [6:0] ST_IRQ_COMMON = 7'h11;
  localparam logic [6:0] ST_IRQ_CH0 = 7'h12;
  localparam logic [6:0] ST_IRQ_CH1 = 7'h13;
  localparam logic [6:0] ST_DEMOD_BASE = 7'h14;  // even codes 0x14..0x1a
  localparam logic [6:0] ST_RESYNC_BASE = 7'h1c;  // codes 0x1c..0x1f
  localparam logic [6:0] ST_REF_A_FAULT = 7'h20;
  localparam logic [6:0] ST_REF_A_ALT_FAULT = 7'h21;

  // internal status bits feeding the status outputs
  typedef struct packed {
    logic watchdog_timeout;
    logic system_clock_source_cal;  // status reg bit 2
    logic system_clock_source_lock;  // bit 0
    logic system_clock_source_stable;  // bit 1
    logic channel0_loop_lock;
    logic channel1_loop_lock;
    logic nv_save;
    logic nv_load;
    logic [1:0] nv_error;  // two fault flags, ored
    logic temp_alarm;
    logic irq_any;
    logic irq_common;
    logic irq_ch0;
    logic irq_ch1;
    logic [3:0] demod_clk;  // a, a alt, b, b alt
    logic [3:0] divider_resync;
    logic reference_input_a_fault;
    logic reference_input_a_alt_fault;
  } status_in_type;

  // control bits toward internal registers
  typedef struct packed {
    logic [NUM_CTRL-1:0] value;  // combined pin level
    logic [NUM_CTRL-1:0] drive;  // slot has at least one pin
  } ctrl_out_type;

endpackage : pin_mapper_pkg

// [hdl/multifunction_pin_code_mapper.sv]
// Contract
// - or group first, then and with rest
// - oe bit one output, zero input
// - seven-bit code picks the function
// - solo codes 00, 10 pass level
// - solo codes 01, 11 invert level
// - control 0x01 drives transfer strobe
// - control 0x02 drives power down
// - control 0x03 watchdog clear; status timeout
// - control 0x04 drives sync all
// - status 0x04-0x06 system_clock_source cal, lock, stable
// - status 0x07 both channel loops locked
// - status 0x08, 0x09 each loop locked
// - status 0x0a, 0x0b save, load busy
// - status 0x0c or of nv faults
// - status 0x0d temperature alarm
// - control 0x10-0x13 clear irq groups
// - status 0x10 any irq event
// - status 0x11-0x13 group irq events
// - demod clocks even, resync 0x1c-0x1f
// - control 0x20, 0x21 force reference faults
// - status 0x20, 0x21 reference faulted flags
module multifunction_pin_code_mapper
  import pin_mapper_pkg::*;
#(
  parameter int NUM_PINS = 7
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // multifunction pins, oe low while driving
  input wire logic [NUM_PINS-1:0] multifunction_pin_in,
  output logic [NUM_PINS-1:0] multifunction_pin_out,
  output logic [NUM_PINS-1:0] multifunction_pin_oe_n,
  // internal status sources
  input wire status_in_type status_i,
  // internal control destinations
  output ctrl_out_type ctrl_o
);

  // all block state in one word
  typedef struct packed {
    logic [NUM_PINS-1:0][7:0] func;  // oe bit and code per pin
    logic [NUM_PINS-1:0][1:0] mode;  // combine code per pin
    logic [NUM_PINS-1:0] pin_out;  // registered status levels
    logic [NUM_CTRL-1:0] ctrl_val;  // held control levels
    logic [NUM_CTRL-1:0] ctrl_drv;  // slots currently owned by pins
    logic core_div;  // toggles every rising edge
    logic [31:0] prdata;
  } state_type;

  state_type state_q;
  state_type state_d;
  logic [15:0] reg_idx;  // word index on the bus
  logic setup_phase;  // first cycle of a transfer
  logic wr_access;  // write takes effect now
  logic mapped;  // address hits a register

  // status code to level; the core clock is sent as a registered half-rate toggle,
  // since a raw clock through a mux would glitch on code changes
  function automatic logic status_level(input logic [6:0] code, input status_in_type s,
                                        input logic core_div);
    logic lvl;
    lvl = 1'b0;  // unassigned codes stay low
    case (code)
      ST_ZERO: lvl = 1'b0;
      ST_ONE: lvl = 1'b1;
      ST_CORE_CLK: lvl = core_div;
      ST_WD_TIMEOUT: lvl = s.watchdog_timeout;
      ST_SYSTEM_CLOCK_SOURCE_CAL: lvl = s.system_clock_source_cal;
      ST_SYSTEM_CLOCK_SOURCE_LOCK: lvl = s.system_clock_source_lock;
      ST_SYSTEM_CLOCK_SOURCE_STABLE: lvl = s.system_clock_source_stable;
      ST_BOTH_LOCK: lvl = s.channel0_loop_lock & s.channel1_loop_lock;
      ST_CH0_LOCK: lvl = s.channel0_loop_lock;
      ST_CH1_LOCK: lvl = s.channel1_loop_lock;
      ST_NV_SAVE: lvl = s.nv_save;
      ST_NV_LOAD: lvl = s.nv_load;
      ST_NV_FAULT: lvl = |s.nv_error;
      ST_TEMP_ALARM: lvl = s.temp_alarm;
      ST_IRQ_ANY: lvl = s.irq_any;
      ST_IRQ_COMMON: lvl = s.irq_common;
      ST_IRQ_CH0: lvl = s.irq_ch0;
      ST_IRQ_CH1: lvl = s.irq_ch1;
      ST_REF_A_FAULT: lvl = s.reference_input_a_fault;
      ST_REF_A_ALT_FAULT: lvl = s.reference_input_a_alt_fault;
      default: begin
        // demod clocks on even codes only, odd ones unassigned
        if (code >= ST_DEMOD_BASE && code < ST_RESYNC_BASE && !code[0]) begin
          lvl = s.demod_clk[2'(code[2:1] - ST_DEMOD_BASE[2:1])];
        end else if (code >= ST_RESYNC_BASE && code < ST_REF_A_FAULT) begin
          lvl = s.divider_resync[code[1:0]];
        end
      end
    endcase
    return lvl;
  endfunction : status_level

  // combined level of all control pins sharing one code
  function automatic logic [1:0] combine(input logic [6:0] code, input state_type st,
                                         input logic [NUM_PINS-1:0] pins);
    logic any_or;
    logic or_term;
    logic and_term;
    logic used;
    logic lvl;
    any_or = 1'b0;
    or_term = 1'b0;
    and_term = 1'b1;
    used = 1'b0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (!st.func[p][OE_BIT] && st.func[p][CODE_MSB:0] == code) begin
        lvl = pins[p] ^ st.mode[p][MODE_INV_BIT];
        used = 1'b1;
        if (st.mode[p][MODE_OR_BIT]) begin
          any_or = 1'b1;
          or_term = or_term | lvl;
        end else begin
          and_term = and_term & lvl;
        end
      end
    end
    // or group reduces first, then joins the and group
    return {used, (or_term | ~any_or) & and_term};
  endfunction : combine

  // bus decode
  always_comb begin
    reg_idx = {6'h00, paddr[11:2]};
    setup_phase = psel & ~penable;
    wr_access = psel & penable & pwrite;
    mapped = (reg_idx == MODE_LO_IDX) || (reg_idx == MODE_HI_IDX) || (reg_idx == PIN_LEVEL_IDX) ||
             (reg_idx >= FUNC_BASE_IDX && reg_idx < FUNC_BASE_IDX + 16'(NUM_PINS));
  end

  // next state: registers, pins, control slots, read data
  always_comb begin
    logic [1:0] res;
    res = 2'b00;
    state_d = state_q;
    state_d.core_div = ~state_q.core_div;
    // register writes, zero wait state
    if (wr_access) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        if (reg_idx == FUNC_BASE_IDX + 16'(p)) begin
          state_d.func[p] = pwdata[7:0];
        end
        if (reg_idx == MODE_LO_IDX + 16'(p / PINS_PER_MODE_REG)) begin
          state_d.mode[p] = pwdata[2*(p%PINS_PER_MODE_REG)+:2];
        end
      end
    end
    // read data captured in setup, stable through access
    if (setup_phase) begin
      state_d.prdata = 32'h0000_0000;
      for (int p = 0; p < NUM_PINS; p++) begin
        if (reg_idx == FUNC_BASE_IDX + 16'(p)) begin
          state_d.prdata[7:0] = state_q.func[p];
        end
        if (reg_idx == MODE_LO_IDX + 16'(p / PINS_PER_MODE_REG)) begin
          state_d.prdata[2*(p%PINS_PER_MODE_REG)+:2] = state_q.mode[p];
        end
      end
      if (reg_idx == PIN_LEVEL_IDX) begin
        state_d.prdata[7:0] = 8'(multifunction_pin_in);
        state_d.prdata[17:8] = state_q.ctrl_val;
        state_d.prdata[29:20] = state_q.ctrl_drv;
      end
    end
    // status outputs
    for (int p = 0; p < NUM_PINS; p++) begin
      state_d.pin_out[p] = state_q.func[p][OE_BIT] &
                           status_level(state_q.func[p][CODE_MSB:0], status_i, state_q.core_div);
    end
    // control slots; an unowned slot keeps its last level
    for (int c = 0; c < NUM_CTRL; c++) begin
      res = combine(CTRL_CODES[c], state_q, multifunction_pin_in);
      state_d.ctrl_drv[c] = res[1];
      if (res[1]) begin
        state_d.ctrl_val[c] = res[0];
      end
    end
  end

  // one register for the whole state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;  // func and mode reset values are zero
    end else begin
      state_q <= state_d;
    end
  end

  // outputs
  always_comb begin
    pready = 1'b1;
    pslverr = psel & penable & ~mapped;
    prdata = state_q.prdata;
    multifunction_pin_out = state_q.pin_out;
    multifunction_pin_oe_n = '1;  // every pin listens unless enabled below
    for (int p = 0; p < NUM_PINS; p++) begin
      multifunction_pin_oe_n[p] = ~state_q.func[p][OE_BIT];
    end
    ctrl_o.value = state_q.ctrl_val;
    ctrl_o.drive = state_q.ctrl_drv;
  end

  // checking helpers: pin 0 alone on the transfer strobe
  logic io_only0;
  logic [6:0] code0;
  logic stat0;
  always_comb begin
    code0 = state_q.func[0][CODE_MSB:0];
    stat0 = state_q.func[0][OE_BIT];
    io_only0 = !stat0 && code0 == CTRL_CODES[CTRL_IO_UPDATE];
    for (int p = 1; p < NUM_PINS; p++) begin
      if (!state_q.func[p][OE_BIT] && state_q.func[p][CODE_MSB:0] == CTRL_CODES[CTRL_IO_UPDATE]) begin
        io_only0 = 1'b0;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_dir_from_oe: assert property (
    wr_access && reg_idx == FUNC_BASE_IDX && pwdata[OE_BIT] |=> !multifunction_pin_oe_n[0] [*2])
    else $error("pin 0 not driving after output enable written");
  a_status_zero: assert property (
    stat0 && code0 == ST_ZERO |=> !multifunction_pin_out[0])
    else $error("status code zero not low");
  a_status_one: assert property (
    stat0 && code0 == ST_ONE |=> multifunction_pin_out[0])
    else $error("status code one not high");
  a_wd_status: assert property (
    stat0 && code0 == ST_WD_TIMEOUT |=> multifunction_pin_out[0] == $past(status_i.watchdog_timeout))
    else $error("watchdog timeout not shown");
  a_both_lock: assert property (
    stat0 && code0 == ST_BOTH_LOCK |=>
      multifunction_pin_out[0] == $past(status_i.channel0_loop_lock && status_i.channel1_loop_lock))
    else $error("both-locked status wrong");
  a_nv_fault: assert property (
    stat0 && code0 == ST_NV_FAULT |=> multifunction_pin_out[0] == $past(|status_i.nv_error))
    else $error("nv fault status wrong");
  a_ref_fault: assert property (
    stat0 && code0 == ST_REF_A_ALT_FAULT |=> multifunction_pin_out[0] == $past(status_i.reference_input_a_alt_fault))
    else $error("reference fault status wrong");
  a_unassigned_low: assert property (
    stat0 && code0 == 7'h0e |=> !multifunction_pin_out[0])
    else $error("unassigned status code not low");
  a_solo_pass: assert property (
    io_only0 && !state_q.mode[0][MODE_INV_BIT] |=>
      ctrl_o.value[CTRL_IO_UPDATE] == $past(multifunction_pin_in[0]) && ctrl_o.drive[CTRL_IO_UPDATE])
    else $error("solo pin not passed through");
  a_solo_invert: assert property (
    io_only0 && state_q.mode[0][MODE_INV_BIT] |=> ctrl_o.value[CTRL_IO_UPDATE] == !$past(multifunction_pin_in[0]))
    else $error("solo pin not inverted");
  a_no_ctrl_hold: assert property (
    1'b1 |=> ((ctrl_o.value ^ $past(ctrl_o.value)) & ~ctrl_o.drive) == '0)
    else $error("unowned control slot changed");
  a_read_ready: assert property (
    setup_phase |=> pready && prdata == $past(state_d.prdata))
    else $error("read data not ready in access phase");

  // configuration writes reach the pin 0 fields one edge later
  a_write_lands: assert property (
    wr_access && reg_idx == FUNC_BASE_IDX |=> state_q.func[0] == $past(pwdata[7:0]))
    else $error("function register write lost");
  // combine code of pin 0 sits in the low mode bits
  a_mode_lands: assert property (
    wr_access && reg_idx == MODE_LO_IDX |=> state_q.mode[0] == $past(pwdata[1:0]))
    else $error("mode register write lost");
  // a control pin never shows a status level
  a_ctrl_pin_low: assert property (
    !stat0 |=> !multifunction_pin_out[0])
    else $error("control pin shows a level");

  // system clock status group, one cycle behind the source
  a_system_clock_source_cal: assert property (
    stat0 && code0 == ST_SYSTEM_CLOCK_SOURCE_CAL |=> multifunction_pin_out[0] == $past(status_i.system_clock_source_cal))
    else $error("system_clock_source calibration status wrong");
  // lock detect
  a_system_clock_source_lock: assert property (
    stat0 && code0 == ST_SYSTEM_CLOCK_SOURCE_LOCK |=> multifunction_pin_out[0] == $past(status_i.system_clock_source_lock))
    else $error("system_clock_source lock status wrong");
  // stable flag
  a_system_clock_source_stable: assert property (
    stat0 && code0 == ST_SYSTEM_CLOCK_SOURCE_STABLE |=> multifunction_pin_out[0] == $past(status_i.system_clock_source_stable))
    else $error("system_clock_source stable status wrong");

  // each channel loop on its own code
  a_ch0_lock: assert property (
    stat0 && code0 == ST_CH0_LOCK |=> multifunction_pin_out[0] == $past(status_i.channel0_loop_lock))
    else $error("channel 0 lock status wrong");
  // second channel loop
  a_ch1_lock: assert property (
    stat0 && code0 == ST_CH1_LOCK |=> multifunction_pin_out[0] == $past(status_i.channel1_loop_lock))
    else $error("channel 1 lock status wrong");

  // nonvolatile store busy flags
  a_nv_save: assert property (
    stat0 && code0 == ST_NV_SAVE |=> multifunction_pin_out[0] == $past(status_i.nv_save))
    else $error("save busy status wrong");
  // load busy
  a_nv_load: assert property (
    stat0 && code0 == ST_NV_LOAD |=> multifunction_pin_out[0] == $past(status_i.nv_load))
    else $error("load busy status wrong");
  // temperature limit
  a_temp_alarm: assert property (
    stat0 && code0 == ST_TEMP_ALARM |=> multifunction_pin_out[0] == $past(status_i.temp_alarm))
    else $error("temperature alarm status wrong");

  // interrupt group summaries
  a_irq_any: assert property (
    stat0 && code0 == ST_IRQ_ANY |=> multifunction_pin_out[0] == $past(status_i.irq_any))
    else $error("any irq status wrong");
  // common group
  a_irq_common: assert property (
    stat0 && code0 == ST_IRQ_COMMON |=> multifunction_pin_out[0] == $past(status_i.irq_common))
    else $error("common irq status wrong");
  // channel 0 group
  a_irq_ch0: assert property (
    stat0 && code0 == ST_IRQ_CH0 |=> multifunction_pin_out[0] == $past(status_i.irq_ch0))
    else $error("channel 0 irq status wrong");
  // channel 1 group
  a_irq_ch1: assert property (
    stat0 && code0 == ST_IRQ_CH1 |=> multifunction_pin_out[0] == $past(status_i.irq_ch1))
    else $error("channel 1 irq status wrong");

  // demod clocks: first even code picks reference a
  a_demod_first: assert property (
    stat0 && code0 == ST_DEMOD_BASE |=> multifunction_pin_out[0] == $past(status_i.demod_clk[0]))
    else $error("first demod clock wrong");
  // odd codes between the demod clocks stay low
  a_demod_odd: assert property (
    stat0 && code0 == ST_DEMOD_BASE + 7'h01 |=> !multifunction_pin_out[0])
    else $error("odd demod code not low");
  // divider resync, first and last reference
  a_resync_first: assert property (
    stat0 && code0 == ST_RESYNC_BASE |=> multifunction_pin_out[0] == $past(status_i.divider_resync[0]))
    else $error("first resync status wrong");
  // last reference resync
  a_resync_last: assert property (
    stat0 && code0 == ST_RESYNC_BASE + 7'h03 |=> multifunction_pin_out[0] == $past(status_i.divider_resync[3]))
    else $error("last resync status wrong");
  // reference a faulted flag
  a_ref_a_fault: assert property (
    stat0 && code0 == ST_REF_A_FAULT |=> multifunction_pin_out[0] == $past(status_i.reference_input_a_fault))
    else $error("reference a fault status wrong");

  c_solo_invert: cover property (io_only0 && state_q.mode[0][MODE_INV_BIT] ##1 ctrl_o.value[CTRL_IO_UPDATE]);
  c_status_out: cover property (stat0 && code0 == ST_IRQ_ANY ##1 multifunction_pin_out[0]);
  c_unmapped: cover property (pslverr);
  // a solo pin passing straight through
  c_solo_pass: cover property (io_only0 && !state_q.mode[0][MODE_INV_BIT] ##1 ctrl_o.value[CTRL_IO_UPDATE]);
  // a status pin showing a reference fault
  c_ref_fault: cover property (stat0 && code0 == ST_REF_A_ALT_FAULT ##1 multifunction_pin_out[0]);

endmodule : multifunction_pin_code_mapper

// [testbench/board_model.sv]
module board_model (
  // pad side of the mapper
  input wire logic [6:0] pin_out,
  input wire logic [6:0] pin_oe_n,
  // levels that the board logic puts on undriven pins
  input wire logic [6:0] board_drive,
  // resolved level seen on each pad
  output logic [6:0] wire_level
);
  timeunit 1ns;
  timeprecision 1ps;

  // the mapper wins where it drives, so a status pin never sees board contention
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      wire_level[i] = pin_oe_n[i] ? board_drive[i] : pin_out[i];
    end
  end
endmodule : board_model

// [testbench/testbench.sv]
module testbench
  import pin_mapper_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int SW = $bits(status_in_type);  // width of the status bundle
  // clock, reset and apb request
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // pads and internal sides
  logic [6:0] pin_in;
  logic [6:0] pin_out;
  logic [6:0] pin_oe_n;
  logic [6:0] board_drive = 7'h00;
  status_in_type status_i = '0;
  ctrl_out_type ctrl_o;
  // bookkeeping
  int miscompares = 0;
  int n_tests = 0;
  logic [31:0] rd;
  logic er;
  logic [31:0] pats [5] = '{32'h0000_0000, 32'hffff_ffff, 32'h0155_5555, 32'h00aa_aaaa, 32'h0123_4567};

  // 50 MHz core clock
  always #10 pclk = ~pclk;

  multifunction_pin_code_mapper #(.NUM_PINS(7)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .multifunction_pin_in(pin_in), .multifunction_pin_out(pin_out),
    .multifunction_pin_oe_n(pin_oe_n), .status_i(status_i), .ctrl_o(ctrl_o));

  board_model board (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .board_drive(board_drive), .wire_level(pin_in));

  // verdict and end of run, also reached from every timeout
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // one comparison, four-state exact
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // apb transfer; holds the request until pready is seen at an edge
  task apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx[9:0], 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      miscompares++;
      final_report();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // config lands one edge after the write, outputs one edge later
  task settle;
    repeat (3) @(posedge pclk);
  endtask : settle

  task func_wr(input int p, input logic [7:0] v);
    apb(1'b1, FUNC_BASE_IDX + 16'(p), {24'h0000_00, v});
  endtask : func_wr

  // expected status level, worked out per code
  function automatic logic exp_st(input logic [6:0] c, input status_in_type s);
    case (c)
      7'h01: return 1'b1;
      7'h03: return s.watchdog_timeout;
      7'h04: return s.system_clock_source_cal;
      7'h05: return s.system_clock_source_lock;
      7'h06: return s.system_clock_source_stable;
      7'h07: return s.channel0_loop_lock & s.channel1_loop_lock;
      7'h08: return s.channel0_loop_lock;
      7'h09: return s.channel1_loop_lock;
      7'h0a: return s.nv_save;
      7'h0b: return s.nv_load;
      7'h0c: return |s.nv_error;
      7'h0d: return s.temp_alarm;
      7'h10: return s.irq_any;
      7'h11: return s.irq_common;
      7'h12: return s.irq_ch0;
      7'h13: return s.irq_ch1;
      7'h14, 7'h16, 7'h18, 7'h1a: return s.demod_clk[2'((c - 7'h14) >> 1)];
      7'h1c, 7'h1d, 7'h1e, 7'h1f: return s.divider_resync[2'(c - 7'h1c)];
      7'h20: return s.reference_input_a_fault;
      7'h21: return s.reference_input_a_alt_fault;
      default: return 1'b0;  // zero code and unassigned codes stay low
    endcase
  endfunction : exp_st

  // hang guard
  initial begin
    #1000000;
    miscompares++;
    final_report();
  end

  // main sequence
  initial begin
    logic a;
    logic [1:0] m;
    logic [3:0] cb;
    status_in_type st;
    int s;
    repeat (2) @(posedge pclk);
    chk(pin_oe_n, 7'h7f);
    chk(ctrl_o, '0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, FUNC_BASE_IDX, 32'h0000_0000);
    chk(rd, {24'h0000_00, FUNC_RESET});
    apb(1'b0, 16'h0200, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(er, 32'h0000_0001);
    func_wr(4, 8'ha1);
    apb(1'b0, FUNC_BASE_IDX + 16'h0004, 32'h0000_0000);
    chk(rd, 32'h0000_00a1);
    func_wr(4, 8'h00);
    // single control pin into every slot, one combine code per slot in rotation
    for (int k = 0; k <= NUM_CTRL; k++) begin
      s = k % NUM_CTRL;
      m = 2'(k + k / NUM_CTRL);  // last pass revisits slot 0 inverted
      apb(1'b1, MODE_LO_IDX, {30'h0, m});
      func_wr(0, {1'b0, CTRL_CODES[s]});
      for (int lv = 0; lv < 2; lv++) begin
        board_drive[0] <= 1'(lv);
        settle();
        chk(ctrl_o.drive, 32'(10'h001 << s));
        chk(ctrl_o.value[s], 1'(lv) ^ m[0]);
      end
    end
    // no-op and unassigned control codes own no slot
    foreach (pats[i]) begin
      func_wr(0, i[0] ? 8'h05 : (i[1] ? 8'h1f : 8'h00));
      settle();
      chk(ctrl_o.drive, 32'h0000_0000);
    end
    // four pins combined on the transfer strobe
    apb(1'b1, MODE_LO_IDX, 32'h0000_0070);
    apb(1'b1, MODE_HI_IDX, 32'h0000_0020);
    func_wr(0, 8'h01);
    func_wr(2, 8'h01);
    func_wr(3, 8'h01);
    func_wr(6, 8'h01);
    for (int c = 0; c < 16; c++) begin
      cb = 4'(c);
      board_drive <= {cb[3], 2'b00, cb[2], cb[1], 1'b0, cb[0]};
      settle();
      chk(pin_oe_n, 7'h7f);
      chk({ctrl_o.drive[0], ctrl_o.value[0]}, {1'b1, (!cb[1] || cb[3]) && cb[0] && !cb[2]});
    end
    apb(1'b0, MODE_LO_IDX, 32'h0000_0000);
    chk(rd, 32'h0000_0070);
    apb(1'b0, PIN_LEVEL_IDX, 32'h0000_0000);
    chk(rd[29:20], 32'h0000_0001);
    // status codes on pins 0 and 1 against several status patterns
    for (int c = 0; c < 34; c++) begin
      if (c != 2) begin
        func_wr(0, {1'b1, 7'(c)});
        func_wr(1, {1'b1, 7'(c)});
        foreach (pats[j]) begin
          st = status_in_type'(pats[j][SW-1:0]);
          status_i <= st;
          settle();
          chk(pin_out[1], exp_st(7'(c), st));
          chk(pin_out[0], exp_st(7'(c), st));
        end
      end
    end
    // core clock code toggles every cycle
    func_wr(1, 8'h82);
    settle();
    chk(pin_oe_n, 7'h7c);
    chk(pin_in[1], pin_out[1]);
    @(negedge pclk);
    a = pin_out[1];
    @(negedge pclk);
    chk(pin_out[1], !a);
    final_report();
  end
endmodule : testbench
